//--- timer_b.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - stop on four received bits when enabled
// RULE2 - stop on receive ignored in trimming modes
// RULE3 - start mode 00b: no automatic start
// RULE4 - start mode 01b: start at transmit end
// RULE5 - mode 10b: trimming, edges, no underflow
// RULE6 - mode 11b: trimming, edges, underflow allowed
// RULE7 - auto reload: reload at zero, continue
// RULE8 - no auto reload: stop at zero
// RULE9 - underflow sets interrupt request flag
// RULE10 - clock select 00b: carrier clock ticks
// RULE11 - clock select 01b: 212 kHz ticks
// RULE12 - 10b/11b: sibling timer underflows decrement
// RULE13 - start event loads both reload bytes
// RULE14 - reload writes leave running count alone
// RULE15 - host avoids count reads during reception
// RULE16 - high bytes are bits 15 to 8
module timer_b (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // register access
  input  wire timer_b_pkg::reg_req_t req,
  input  wire logic                  irq_clear,
  output logic [7:0]                 rdata,
  // events
  input  wire timer_b_pkg::events_t  ev,
  input  wire logic                  sw_start,
  input  wire logic                  sw_stop,
  // status
  output logic                       running,
  output logic                       underflow_irq_flag
);

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_run  = 2'b10
  } state_t;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  control_ff;
  logic [7:0]  reload_high_byte_ff;
  logic [7:0]  reload_low_byte_ff;
  logic [15:0] count_ff;
  logic        trim_ref_ff;
  state_t      state_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic        running_ff;

  wire logic [1:0]  start_mode_select =
    control_ff[timer_b_pkg::start_mode_hi_bit:timer_b_pkg::start_mode_lo_bit];
  wire logic [1:0]  count_clock_select =
    control_ff[timer_b_pkg::count_clock_hi_bit:
               timer_b_pkg::count_clock_lo_bit];
  wire logic        stop_on_receive =
    control_ff[timer_b_pkg::stop_on_receive_bit];
  wire logic        auto_reload_enable =
    control_ff[timer_b_pkg::auto_reload_enable_bit];
  wire logic [15:0] reload_value =
    {reload_high_byte_ff, reload_low_byte_ff}; // see RULE16

  wire logic trim_mode  =
    (start_mode_select == timer_b_pkg::start_trim) |
    (start_mode_select == timer_b_pkg::start_trim_uf); // see RULE5 see RULE6
  wire logic trim_edge  = ev.trim_ref & ~trim_ref_ff;
  wire logic is_run     = (state_ff == st_run);

  // clock select as a tick enable; everything stays on clk
  wire logic tick =
    (count_clock_select == timer_b_pkg::clk_carrier)    ? ev.carrier_tick :
    (count_clock_select == timer_b_pkg::clk_derived)    ? ev.derived_tick :
    (count_clock_select == timer_b_pkg::clk_timer_zero) ?
      ev.timer_zero_underflow :
      ev.timer_one_underflow; // see RULE10 see RULE11 see RULE12

  // hardware start: none in mode 00b
  wire logic hw_start =
    ((start_mode_select == timer_b_pkg::start_after_tx) & ev.tx_end) |
    (trim_mode & trim_edge & ~is_run); // see RULE3 see RULE4
  wire logic start_evt = sw_start | hw_start;

  wire logic rx_stop = stop_on_receive & ~trim_mode & ev.rx_four_bits;
  // see RULE1 see RULE2
  wire logic trim_stop = trim_mode & trim_edge & is_run; // see RULE5
  wire logic stop_evt  = sw_stop | rx_stop | trim_stop;

  wire logic at_zero   = (count_ff == timer_b_pkg::count_zero);
  wire logic underflow = is_run & tick & at_zero &
    (start_mode_select != timer_b_pkg::start_trim); // see RULE5 see RULE6

  // write strobes
  wire logic wr_ctl = req.wr & (req.addr == timer_b_pkg::timer_b_control_addr);
  wire logic wr_rhi =
    req.wr & (req.addr == timer_b_pkg::timer_b_reload_high_addr);
  wire logic wr_rlo =
    req.wr & (req.addr == timer_b_pkg::timer_b_reload_low_addr);

  logic [7:0] nxt_rdata;
  always_comb begin
    if (req.addr == timer_b_pkg::timer_b_control_addr) begin
      nxt_rdata = control_ff;
    end else if (req.addr == timer_b_pkg::timer_b_reload_high_addr) begin
      nxt_rdata = reload_high_byte_ff;
    end else if (req.addr == timer_b_pkg::timer_b_reload_low_addr) begin
      nxt_rdata = reload_low_byte_ff;
    end else if (req.addr == timer_b_pkg::timer_b_count_high_addr) begin
      nxt_rdata = count_ff[15:8]; // see RULE16
    end else if (req.addr == timer_b_pkg::timer_b_count_low_addr) begin
      nxt_rdata = count_ff[7:0];
    end else begin
      nxt_rdata = timer_b_pkg::byte_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter next state; start wins over stop, a restart reloads
  logic [15:0] nxt_count;
  state_t      nxt_state;
  always_comb begin
    nxt_count = count_ff;
    nxt_state = state_ff;
    if (start_evt) begin
      nxt_count = reload_value; // see RULE13
      nxt_state = st_run;
    end else if (stop_evt) begin
      nxt_state = st_idle; // see RULE1
    end else if (is_run & tick) begin
      if (at_zero) begin
        if (underflow & auto_reload_enable) begin
          nxt_count = reload_value; // see RULE7
        end else begin
          nxt_state = st_idle; // see RULE8 see RULE5
        end
      end else begin
        nxt_count = count_ff - timer_b_pkg::count_one;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control_ff <= timer_b_pkg::control_reset;
    end else if (wr_ctl) begin
      control_ff <= req.wdata & timer_b_pkg::control_write_mask;
    end
  end

  // reload bytes only stored; count takes them at a start or an auto reload
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_high_byte_ff <= timer_b_pkg::byte_reset;
      reload_low_byte_ff  <= timer_b_pkg::byte_reset;
    end else begin
      if (wr_rhi) reload_high_byte_ff <= req.wdata; // see RULE14
      if (wr_rlo) reload_low_byte_ff  <= req.wdata; // see RULE14
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff    <= timer_b_pkg::count_reset;
      state_ff    <= st_idle;
      trim_ref_ff <= 1'b0;
      rdata_ff    <= timer_b_pkg::byte_reset;
      running_ff  <= 1'b0;
    end else begin
      count_ff    <= nxt_count;
      state_ff    <= nxt_state;
      trim_ref_ff <= ev.trim_ref;
      rdata_ff    <= nxt_rdata;
      running_ff  <= (nxt_state == st_run);
    end
  end

  // set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else if (underflow) begin
      irq_ff <= 1'b1; // see RULE9
    end else if (irq_clear) begin
      irq_ff <= 1'b0;
    end
  end

  assign rdata              = rdata_ff;
  assign running            = running_ff;
  assign underflow_irq_flag = irq_ff;

  ////////////////////////////////////////////////////////////////////////
  property p_rx_stop;
    @(posedge clk) disable iff (!rst_b)
      (rx_stop & ~start_evt) |=> !is_run;
  endproperty
  a_rx_stop: assert property (p_rx_stop) // see RULE1
    else $error("rx stop missed");

  property p_trim_rx_ignored;
    @(posedge clk) disable iff (!rst_b)
      (is_run & trim_mode & ev.rx_four_bits & ~trim_edge & ~sw_stop &
       ~(tick & at_zero)) |=> is_run;
  endproperty
  a_trim_rx_ignored: assert property (p_trim_rx_ignored) // see RULE2
    else $error("rx stopped trim");

  property p_no_auto_start;
    @(posedge clk) disable iff (!rst_b)
      (!is_run & ~sw_start & start_mode_select == timer_b_pkg::start_none)
        |=> !is_run;
  endproperty
  a_no_auto_start: assert property (p_no_auto_start) // see RULE3
    else $error("auto start in mode 0");

  property p_tx_start;
    @(posedge clk) disable iff (!rst_b)
      (start_mode_select == timer_b_pkg::start_after_tx & ev.tx_end)
        |=> (is_run & count_ff == $past(reload_value));
  endproperty
  a_tx_start: assert property (p_tx_start) // see RULE4 see RULE13
    else $error("tx start missed");

  property p_trim_no_uf;
    @(posedge clk) disable iff (!rst_b)
      (start_mode_select == timer_b_pkg::start_trim) |-> !underflow;
  endproperty
  a_trim_no_uf: assert property (p_trim_no_uf) // see RULE5
    else $error("trim underflow");

  property p_reload;
    @(posedge clk) disable iff (!rst_b)
      (underflow & auto_reload_enable & ~start_evt & ~stop_evt)
        |=> (is_run & count_ff == $past(reload_value));
  endproperty
  a_reload: assert property (p_reload) // see RULE7 see RULE6
    else $error("no reload");

  property p_stop_zero;
    @(posedge clk) disable iff (!rst_b)
      (is_run & tick & at_zero & ~auto_reload_enable & ~start_evt)
        |=> !is_run;
  endproperty
  a_stop_zero: assert property (p_stop_zero) // see RULE8
    else $error("no stop at zero");

  sequence s_underflow;
    underflow;
  endsequence
  property p_irq;
    @(posedge clk) disable iff (!rst_b)
      s_underflow |=> underflow_irq_flag;
  endproperty
  a_irq: assert property (p_irq) // see RULE9
    else $error("irq not set");

  property p_decrement;
    @(posedge clk) disable iff (!rst_b)
      (is_run & tick & ~at_zero & ~start_evt & ~stop_evt)
        |=> count_ff == $past(count_ff) - timer_b_pkg::count_one;
  endproperty
  a_decrement: assert property (p_decrement) // see RULE10 RULE11 RULE12
    else $error("bad decrement");

  property p_hold;
    @(posedge clk) disable iff (!rst_b)
      (is_run & ~tick & ~start_evt) |=> count_ff == $past(count_ff);
  endproperty
  a_hold: assert property (p_hold) // see RULE14
    else $error("count moved");

  property p_count_read;
    @(posedge clk) disable iff (!rst_b)
      (req.addr == timer_b_pkg::timer_b_count_high_addr)
        |=> rdata == $past(count_ff[15:8]);
  endproperty
  a_count_read: assert property (p_count_read) // see RULE16
    else $error("bad high read");

  // one step per tick of the selected source only
  sequence s_count_ready;
    is_run & ~at_zero & ~start_evt & ~stop_evt;
  endsequence
  sequence s_count_stepped;
    count_ff == $past(count_ff) - timer_b_pkg::count_one;
  endsequence

  property p_carrier_step;
    @(posedge clk) disable iff (!rst_b)
      (count_clock_select == timer_b_pkg::clk_carrier &
       ev.carrier_tick) ##0 s_count_ready |=> s_count_stepped;
  endproperty
  a_carrier_step: assert property (p_carrier_step) // see RULE10
    else $error("carrier tick missed");

  property p_derived_step;
    @(posedge clk) disable iff (!rst_b)
      (count_clock_select == timer_b_pkg::clk_derived &
       ev.derived_tick) ##0 s_count_ready |=> s_count_stepped;
  endproperty
  a_derived_step: assert property (p_derived_step) // see RULE11
    else $error("derived tick missed");

  property p_zero_step;
    @(posedge clk) disable iff (!rst_b)
      (count_clock_select == timer_b_pkg::clk_timer_zero &
       ev.timer_zero_underflow) ##0 s_count_ready |=> s_count_stepped;
  endproperty
  a_zero_step: assert property (p_zero_step) // see RULE12
    else $error("timer zero underflow missed");

  property p_one_step;
    @(posedge clk) disable iff (!rst_b)
      (count_clock_select == timer_b_pkg::clk_timer_one &
       ev.timer_one_underflow) ##0 s_count_ready |=> s_count_stepped;
  endproperty
  a_one_step: assert property (p_one_step) // see RULE12
    else $error("timer one underflow missed");

  property p_reload_write_kept;
    @(posedge clk) disable iff (!rst_b)
      (is_run & ~tick & ~start_evt & (wr_rhi | wr_rlo))
        |=> count_ff == $past(count_ff);
  endproperty
  a_reload_write_kept: assert property (p_reload_write_kept) // see RULE14
    else $error("reload write moved count");

  property p_count_low_read;
    @(posedge clk) disable iff (!rst_b)
      (req.addr == timer_b_pkg::timer_b_count_low_addr)
        |=> rdata == $past(count_ff[7:0]);
  endproperty
  a_count_low_read: assert property (p_count_low_read) // see RULE16
    else $error("bad low read");

  property p_trim_uf;
    @(posedge clk) disable iff (!rst_b)
      (start_mode_select == timer_b_pkg::start_trim_uf &
       is_run & tick & at_zero) |=> underflow_irq_flag;
  endproperty
  a_trim_uf: assert property (p_trim_uf) // see RULE6
    else $error("trim underflow missed");

  property p_trim_start;
    @(posedge clk) disable iff (!rst_b)
      (trim_mode & $rose(ev.trim_ref) & !is_run)
        |=> (is_run & count_ff == $past(reload_value));
  endproperty
  a_trim_start: assert property (p_trim_start) // see RULE5 see RULE6
    else $error("trim edge start missed");

  property p_trim_stop;
    @(posedge clk) disable iff (!rst_b)
      (trim_mode & $rose(ev.trim_ref) & is_run & ~sw_start) |=> !is_run;
  endproperty
  a_trim_stop: assert property (p_trim_stop) // see RULE5 see RULE6
    else $error("trim edge stop missed");

endmodule

//--- timer_b_bench.sv
`timescale 1ns/1ps
module timer_b_bench;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  timer_b_pkg::reg_req_t req;
  logic                  irq_clear;
  logic [7:0]            rdata;
  timer_b_pkg::events_t  ev;
  logic                  sw_start;
  logic                  sw_stop;
  logic                  running;
  logic                  underflow_irq_flag;
  int                    errors = 0;
  int                    checked = 0;
  int                    seed = 24518;
  logic [31:0]           r;
  logic [31:0]           r2;
  // model state, all plain integers
  int ctrl = 0, rhi = 0, rlo = 0, cnt = 0, run = 0, flag = 0, trim_q = 0;
  int rd = 0;
  int mode, csel, tick, st, sp, rise;

  always #5 clk = ~clk;

  timer_b timer_b_inst (
    .clk                (clk),
    .rst_b              (rst_b),
    .req                (req),
    .irq_clear          (irq_clear),
    .rdata              (rdata),
    .ev                 (ev),
    .sw_start           (sw_start),
    .sw_stop            (sw_stop),
    .running            (running),
    .underflow_irq_flag (underflow_irq_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reference model: state before the edge decides, like registers do
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl = 0;
      rhi = 0;
      rlo = 0;
      cnt = 0;
      run = 0;
      flag = 0;
      trim_q = 0;
      rd = 0;
    end else begin
      mode = (ctrl >> 4) & 3;
      csel = ctrl & 3;
      case (csel)
        0: tick = ev.carrier_tick;
        1: tick = ev.derived_tick;
        2: tick = ev.timer_zero_underflow;
        default: tick = ev.timer_one_underflow;
      endcase
      rise = ev.trim_ref && !trim_q;
      st = sw_start || (mode == 1 && ev.tx_end)
           || (mode >= 2 && rise && !run);
      sp = sw_stop || (mode >= 2 && rise && run)
           || (mode < 2 && ctrl[7] && ev.rx_four_bits);
      case (req.addr)
        8'h19: rd = ctrl;
        8'h1a: rd = rhi;
        8'h1b: rd = rlo;
        8'h1c: rd = cnt >> 8;
        8'h1d: rd = cnt & 255;
        default: rd = 0;
      endcase
      if (irq_clear) flag = 0;
      // a tick at zero underflows even if a start or stop lands with it
      if (run && tick && cnt == 0 && mode != 2) flag = 1;
      if (st) begin
        cnt = rhi * 256 + rlo;
        run = 1;
      end else if (sp) begin
        run = 0;
      end else if (run && tick) begin
        if (cnt > 0) cnt = cnt - 1;
        else if (mode == 2) run = 0;
        else begin
          if (ctrl & 8) cnt = rhi * 256 + rlo;
          else run = 0;
        end
      end
      if (req.wr) begin
        if (req.addr == 8'h19) ctrl = req.wdata & 8'hbb;
        if (req.addr == 8'h1a) rhi = req.wdata;
        if (req.addr == 8'h1b) rlo = req.wdata;
      end
      trim_q = ev.trim_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (exp !== got) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(string name, logic exp, logic got);
    checked++;
    if (exp !== got) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // outputs are settled by the falling edge
  always @(negedge clk) begin
    check_byte("rdata", rd[7:0], rdata);
    check_bit("running", run[0], running);
    check_bit("irq_flag", flag[0], underflow_irq_flag);
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    ev = '0;
    irq_clear = 1'b0;
    sw_start = 1'b0;
    sw_stop = 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk);
      r = $random(seed);
      r2 = $random(seed);
      // small reload values so the count reaches zero often
      req.wr <= (r[2:0] == 3'h0);
      // the host keeps count reads away from a receive event
      if (r2[20:17] == 4'h0 && r[6:5] == 2'h2) req.addr <= 8'h19;
      else req.addr <= 8'h18 + {5'h00, r[6:4]};
      if (r[6:4] == 3'h2) req.wdata <= {7'h00, r[7]};
      else if (r[6:4] == 3'h3 && !r2[8]) req.wdata <= {4'h0, r2[3:0]};
      else req.wdata <= r2[7:0];
      irq_clear <= (r[11:8] == 4'h0);
      sw_start <= (r[17:12] == 6'h00);
      sw_stop <= (r[23:18] == 6'h00);
      ev.carrier_tick <= r2[9];
      ev.derived_tick <= r2[10];
      ev.timer_zero_underflow <= r2[11];
      ev.timer_one_underflow <= r2[12];
      ev.tx_end <= (r2[16:13] == 4'h0);
      ev.rx_four_bits <= (r2[20:17] == 4'h0);
      if (r2[24:21] == 4'h0) ev.trim_ref <= ~ev.trim_ref;
      // a second reset in mid-run
      if (i == 3000) rst_b <= 1'b0;
      if (i == 3008) rst_b <= 1'b1;
    end
    end_sim();
  end
endmodule

//--- timer_b_pkg.sv
package timer_b_pkg;

  // register addresses (byte-wide register space)
  localparam logic [7:0] timer_b_control_addr     = 8'h19;
  localparam logic [7:0] timer_b_reload_high_addr = 8'h1a;
  localparam logic [7:0] timer_b_reload_low_addr  = 8'h1b;
  localparam logic [7:0] timer_b_count_high_addr  = 8'h1c;
  localparam logic [7:0] timer_b_count_low_addr   = 8'h1d;

  // control field positions
  localparam int stop_on_receive_bit    = 7;
  localparam int start_mode_hi_bit      = 5;
  localparam int start_mode_lo_bit      = 4;
  localparam int auto_reload_enable_bit = 3;
  localparam int count_clock_hi_bit     = 1;
  localparam int count_clock_lo_bit     = 0;

  // writable bits of the control byte; bits 6 and 2 read as zero
  localparam logic [7:0] control_write_mask = 8'hbb;
  localparam logic [7:0] control_reset      = 8'h00;
  localparam logic [7:0] byte_reset         = 8'h00;
  localparam logic [15:0] count_reset       = 16'h0000;
  localparam logic [15:0] count_zero        = 16'h0000;
  localparam logic [15:0] count_one         = 16'h0001;

  localparam logic [1:0] start_none     = 2'h0;
  localparam logic [1:0] start_after_tx = 2'h1;
  localparam logic [1:0] start_trim     = 2'h2;
  localparam logic [1:0] start_trim_uf  = 2'h3;

  localparam logic [1:0] clk_carrier    = 2'h0;
  localparam logic [1:0] clk_derived    = 2'h1;
  localparam logic [1:0] clk_timer_zero = 2'h2;
  localparam logic [1:0] clk_timer_one  = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } reg_req_t;

  // one-cycle event strobes from neighbouring logic; trim_ref is a level whose rising edge is used
  typedef struct packed {
    logic carrier_tick;
    logic derived_tick;
    logic timer_zero_underflow;
    logic timer_one_underflow;
    logic tx_end;
    logic rx_four_bits;
    logic trim_ref;
  } events_t;

endpackage
